// >>> core/sorc_core.sv
// Safety output pair control, restart interlock and output routing
//
// Contract
// - four-field mode evaluates two protective and two warning fields.
// - protective field A violated switches safety output pair A off.
// - protective field B violation only raises a non-safe indication.
// - each protective function has its own warning-field violation signal.
// - each logical signal goes to its configured physical output.
// - one resolution per bank, chosen from 30 mm up to 150 mm.
// - one configured maximum vehicle speed per bank.
// - safety outputs off no later than the configured response time.
// - one start-up mode applies to the whole bank.
// - automatic mode enables outputs without reset at power-up and free.
// - start interlock mode holds outputs off after power-up until reset.
// - start interlock mode re-enables automatically once the field clears.
// - reset press counts only if held between 0.12 s and 4 s.
// - full interlock keeps outputs off after field cleared until reset.
// - full interlock keeps outputs off after power-up until reset.
module sorc_core
  import sorc_pkg::*;
#(
  parameter int unsigned P_RST_MIN_CYC = RST_MIN_CYC,
  parameter int unsigned P_RST_MAX_CYC = RST_MAX_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pf_a_viol,
  input wire logic i_pf_b_viol,
  input wire logic i_wf_a_viol,
  input wire logic i_wf_b_viol,
  input wire logic i_reset_button,
  input wire logic i_aux_inout_one,
  output logic o_aux_inout_one,
  output logic o_aux_inout_one_oe_n,
  output logic [1:0] o_safety_output_pair_a,
  output logic o_nonsafe_message_output,
  output logic o_aux_output_one,
  output sorc_bank_t o_bank_cfg,
  output logic o_irq,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  // Resolution code to millimetres, zero for an unsupported code
  function automatic logic [7:0] res_mm(input logic [2:0] code);
    case (code)
      3'h0: res_mm = 8'h1E;
      3'h1: res_mm = 8'h28;
      3'h2: res_mm = 8'h32;
      3'h3: res_mm = 8'h3C;
      3'h4: res_mm = 8'h46;
      3'h5: res_mm = 8'h96;
      default: res_mm = 8'h00;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers: every pin passes two flops first
  localparam int N_SYNC = 6;
  localparam int SYN_BTN = 4;
  localparam int SYN_AUX = 5;
  logic [N_SYNC-1:0] meta_q;
  logic [N_SYNC-1:0] sync_q;
  logic [N_SYNC-1:0] pins;

  assign pins = {i_aux_inout_one, i_reset_button, i_wf_b_viol,
                 i_wf_a_viol, i_pf_b_viol, i_pf_a_viol};

  // First stage is read only by the second
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file state
  sorc_ctrl_t ctrl_q, ctrl_d;
  sorc_route_t route_q, route_d;
  logic [EV_W-1:0] irq_st_q, irq_st_d;
  logic [EV_W-1:0] irq_en_q, irq_en_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [EV_W-1:0] events;
  logic wr_go;
  logic [31:0] status_word;

  //////////////////////////////////////////////////////////////////////////
  // Field evaluation
  logic pf_a;
  logic pf_b;
  logic wf_a;
  logic wf_b;
  logic cfg_ok;
  logic [3:0] sigs;

  // Outside four-field mode the B pair is not monitored at all
  assign pf_a = sync_q[SIG_PF_A];
  assign pf_b = sync_q[SIG_PF_B] & ctrl_q.four_field;
  assign wf_a = sync_q[SIG_WF_A];
  assign wf_b = sync_q[SIG_WF_B] & ctrl_q.four_field;
  // Unsupported resolution or mode code keeps the pair off
  assign cfg_ok = (res_mm(ctrl_q.res_code) != 8'h00)
                  && (ctrl_q.mode != SORC_MODE_SPARE);

  // Logical violation signals, one warning signal per function
  assign sigs[SIG_PF_A] = pf_a;
  assign sigs[SIG_PF_B] = pf_b;
  assign sigs[SIG_WF_A] = wf_a;
  assign sigs[SIG_WF_B] = wf_b;

  //////////////////////////////////////////////////////////////////////////
  // Reset-button press timer
  logic [PRESS_W-1:0] press_q, press_d;
  logic btn_q, btn_d;
  logic rst_ok;
  logic rst_bad;
  logic btn;

  assign btn = sync_q[SYN_BTN];

  // Count while held, saturate past the long limit; judge on release
  always_comb begin
    btn_d = btn;
    press_d = press_q;
    rst_ok = 1'b0;
    rst_bad = 1'b0;
    if (btn) begin
      if (press_q <= PRESS_W'(P_RST_MAX_CYC)) begin
        press_d = press_q + PRESS_W'(1);
      end
    end else begin
      press_d = '0;
      if (btn_q) begin
        if (press_q >= PRESS_W'(P_RST_MIN_CYC)
            && press_q <= PRESS_W'(P_RST_MAX_CYC)) begin
          rst_ok = 1'b1;
        end else begin
          rst_bad = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      press_q <= '0;
      btn_q <= 1'b0;
    end else begin
      press_q <= press_d;
      btn_q <= btn_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Start-up and restart state machine, one mode for the bank
  sorc_state_t st_q, st_d;
  logic ev_trip;
  logic ev_enable;

  always_comb begin
    st_d = st_q;
    ev_trip = 1'b0;
    ev_enable = 1'b0;
    case (st_q)
      // Power-up lands here; only automatic mode leaves without a press
      SORC_ST_LOCKED: begin
        if (!pf_a && cfg_ok) begin
          if (ctrl_q.mode == SORC_MODE_AUTO) begin
            st_d = SORC_ST_ON;
          end else if (rst_ok) begin
            st_d = SORC_ST_ON;
          end
        end
      end
      SORC_ST_ON: begin
        if (pf_a || !cfg_ok) begin
          st_d = SORC_ST_TRIPPED;
          ev_trip = 1'b1;
        end
      end
      SORC_ST_TRIPPED: begin
        if (!pf_a && cfg_ok) begin
          case (ctrl_q.mode)
            SORC_MODE_AUTO: st_d = SORC_ST_ON;
            SORC_MODE_START_LOCK: st_d = SORC_ST_ON;
            default: st_d = SORC_ST_LOCKED;
          endcase
        end
      end
      default: st_d = SORC_ST_LOCKED;
    endcase
    if (st_d == SORC_ST_ON && st_q != SORC_ST_ON) begin
      ev_enable = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_q <= SORC_ST_LOCKED;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Physical outputs, all from flops
  logic [1:0] pair_d;
  logic [N_PHYS-1:0] phys_d;
  logic [N_PHYS-1:0] phys_q;
  logic [1:0] pair_q;
  logic oe_n_q, oe_n_d;
  logic [1:0] sel [N_PHYS];

  assign sel[0] = route_q.sel_message;
  assign sel[1] = route_q.sel_aux_one;
  assign sel[2] = route_q.sel_inout_one;

  // A synchronised violation cuts the pair in the next cycle, well inside
  // any response time, without waiting for the state machine
  assign pair_d = (st_q == SORC_ST_ON && !pf_a && cfg_ok)
                  ? 2'b11 : 2'b00;

  genvar g;
  generate
    for (g = 0; g < N_PHYS; g++) begin : g_route
      assign phys_d[g] = sigs[sel[g]];
    end
  endgenerate

  assign oe_n_d = ~ctrl_q.aux_drive;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pair_q <= 2'b00;
      phys_q <= '0;
      oe_n_q <= 1'b1;
    end else begin
      pair_q <= pair_d;
      phys_q <= phys_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign o_safety_output_pair_a = pair_q;
  assign o_nonsafe_message_output = phys_q[0];
  assign o_aux_output_one = phys_q[1];
  assign o_aux_inout_one = phys_q[2];
  assign o_aux_inout_one_oe_n = oe_n_q;

  // Bank settings for the field evaluation
  assign o_bank_cfg.res_mm = res_mm(ctrl_q.res_code);
  assign o_bank_cfg.max_speed = ctrl_q.max_speed;
  assign o_bank_cfg.response_ms = ctrl_q.response_ms;

  //////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the access completes
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign wr_go = i_avs_write & ack_q;
  assign o_avs_readdata = rdata_q;

  assign events[EV_TRIP] = ev_trip;
  assign events[EV_ENABLE] = ev_enable;
  assign events[EV_RST_OK] = rst_ok;
  assign events[EV_RST_BAD] = rst_bad;

  assign status_word = {8'h00, res_mm(ctrl_q.res_code), 7'h00, cfg_ok,
                        sync_q[SYN_AUX], wf_b, wf_a, pf_b, pf_a,
                        pair_q[0], st_q};

  // Decode, write and interrupt update; a new event beats a clear
  always_comb begin
    ack_d = (i_avs_read | i_avs_write) & ~ack_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    route_d = route_q;
    irq_en_d = irq_en_q;
    irq_st_d = irq_st_q;
    if (wr_go && i_avs_address == OFS_IRQ_CLEAR) begin
      irq_st_d = irq_st_q & ~i_avs_writedata[EV_W-1:0];
    end
    irq_st_d = irq_st_d | events;
    if (wr_go) begin
      case (i_avs_address)
        OFS_CTRL: begin
          ctrl_d = i_avs_writedata;
          ctrl_d.rsvd_hi = '0;
          ctrl_d.rsvd_lo = 1'b0;
        end
        OFS_ROUTE: begin
          route_d = i_avs_writedata;
          route_d.rsvd = '0;
        end
        OFS_IRQ_ENABLE: irq_en_d = i_avs_writedata[EV_W-1:0];
        default: ;
      endcase
    end
    if (ack_d && i_avs_read) begin
      case (i_avs_address)
        OFS_CTRL: rdata_d = ctrl_q;
        OFS_ROUTE: rdata_d = route_q;
        OFS_STATUS: rdata_d = status_word;
        OFS_IRQ_STATUS: rdata_d = {28'h000_0000, irq_st_q};
        OFS_IRQ_ENABLE: rdata_d = {28'h000_0000, irq_en_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RST;
      route_q <= ROUTE_RST;
      irq_st_q <= '0;
      irq_en_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      route_q <= route_d;
      irq_st_q <= irq_st_d;
      irq_en_q <= irq_en_d;
    end
  end

  // Level interrupt while any enabled status bit stands
  assign o_irq = |(irq_st_q & irq_en_q);

endmodule

// >>> include/sorc_pkg.sv
// Shared constants and types of the safety output and restart control block
package sorc_pkg;
  // Clock rate and reset-button timing
  localparam int CLK_KHZ = 40_000;
  localparam int RST_MIN_MS = 120;
  localparam int RST_MAX_MS = 4000;
  // Both figures are whole cycles, so round-up and round-down agree
  localparam int RST_MIN_CYC = RST_MIN_MS * CLK_KHZ;
  localparam int RST_MAX_CYC = RST_MAX_MS * CLK_KHZ;
  localparam int PRESS_W = 28;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_ROUTE = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h0C;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h10;
  localparam logic [4:0] OFS_IRQ_CLEAR = 5'h14;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0014_0002;
  localparam logic [31:0] ROUTE_RST = 32'h0000_0039;
  localparam int EV_W = 4;

  // Event bit positions
  localparam int EV_TRIP = 0;
  localparam int EV_ENABLE = 1;
  localparam int EV_RST_OK = 2;
  localparam int EV_RST_BAD = 3;

  // Logical signals that can be routed to a physical output
  localparam int SIG_PF_A = 0;
  localparam int SIG_PF_B = 1;
  localparam int SIG_WF_A = 2;
  localparam int SIG_WF_B = 3;
  localparam int N_PHYS = 3;

  typedef enum logic [1:0] {
    SORC_MODE_AUTO = 2'b00,
    SORC_MODE_START_LOCK = 2'b01,
    SORC_MODE_FULL_LOCK = 2'b10,
    SORC_MODE_SPARE = 2'b11
  } sorc_mode_t;

  typedef enum logic [1:0] {
    SORC_ST_LOCKED = 2'b00,
    SORC_ST_ON = 2'b01,
    SORC_ST_TRIPPED = 2'b10
  } sorc_state_t;

  // Control word: one setting set shared by the whole bank
  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [7:0] response_ms;
    logic [7:0] max_speed;
    logic aux_drive;
    logic [2:0] res_code;
    logic rsvd_lo;
    logic four_field;
    sorc_mode_t mode;
  } sorc_ctrl_t;

  // Selector per physical non-safe output
  typedef struct packed {
    logic [25:0] rsvd;
    logic [1:0] sel_inout_one;
    logic [1:0] sel_aux_one;
    logic [1:0] sel_message;
  } sorc_route_t;

  // Bank settings handed to the field evaluation
  typedef struct packed {
    logic [7:0] res_mm;
    logic [7:0] max_speed;
    logic [7:0] response_ms;
  } sorc_bank_t;
endpackage

// >>> verification/sorc_core_sva.sv
// Assertion checker for the safety output and restart control
module sorc_core_sva
  import sorc_pkg::*;
#(
  parameter int unsigned P_RST_MIN_CYC = RST_MIN_CYC,
  parameter int unsigned P_RST_MAX_CYC = RST_MAX_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pf_a_viol,
  input wire logic i_reset_button,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  input wire logic [1:0] o_safety_output_pair_a
);
  logic [1:0] mode_q;
  int unsigned cnt_q;
  logic [1:0] pr;
  assign pr = o_safety_output_pair_a;
  ////////////////////////////////////////////////////////////////////
  // Mode mirror and press length; bus-only view keeps it cheap
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mode_q <= 2'h2;
      cnt_q <= 0;
    end else begin
      cnt_q <= i_reset_button ? cnt_q + 1 : 0;
      if (i_avs_write && !o_avs_waitrequest && i_avs_address == OFS_CTRL)
        mode_q <= i_avs_writedata[1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_req; $rose(i_avs_read || i_avs_write); endsequence
  sequence s_ack; o_avs_waitrequest ##1 !o_avs_waitrequest; endsequence
  sequence s_trip; $rose(i_pf_a_viol) ##1 i_pf_a_viol[*3]; endsequence
  sequence s_fall; mode_q == 2'h2 && $fell(i_reset_button); endsequence
  property p_wait; s_req |-> s_ack; endproperty
  property p_idle; !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
  endproperty
  property p_trip; s_trip |-> pr == 2'b00; endproperty
  property p_held; i_pf_a_viol[*4] |-> pr == 2'b00; endproperty
  property p_legal; pr == 2'b00 || pr == 2'b11; endproperty
  property p_auto; (mode_q == 2'h0 && !i_pf_a_viol)[*8] |-> pr == 2'b11;
  endproperty
  property p_lock;
    (mode_q == 2'h2 && !i_reset_button)[*6] ##0 pr == 2'b00 |=> pr == 2'b00;
  endproperty
  property p_press;
    s_fall ##0 (!i_pf_a_viol && cnt_q >= P_RST_MIN_CYC &&
      cnt_q <= P_RST_MAX_CYC) |-> ##[1:8] pr == 2'b11;
  endproperty
  property p_rej;
    s_fall ##0 (pr == 2'b00 && (cnt_q < P_RST_MIN_CYC ||
      cnt_q > P_RST_MAX_CYC)) |=> (pr == 2'b00)[*8];
  endproperty
  a_wait: assert property (p_wait) else $error("wait cycle wrong");
  a_idle: assert property (p_idle) else $error("wait while idle");
  a_trip: assert property (p_trip) else $error("no trip");
  a_held: assert property (p_held) else $error("pair on");
  a_legal: assert property (p_legal) else $error("pair split");
  a_auto: assert property (p_auto) else $error("no auto on");
  a_lock: assert property (p_lock) else $error("lock lost");
  a_press: assert property (p_press) else $error("press lost");
  a_rej: assert property (p_rej) else $error("bad press taken");
endmodule
bind sorc_core sorc_core_sva #(
  .P_RST_MIN_CYC(P_RST_MIN_CYC),
  .P_RST_MAX_CYC(P_RST_MAX_CYC)
) u_sorc_core_sva (.i_clk, .i_reset, .i_pf_a_viol, .i_reset_button,
  .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .o_avs_waitrequest, .o_safety_output_pair_a);

// >>> verification/sorc_operator.sv
// Operator model: reset button held for a chosen time
module sorc_operator (
  input wire logic i_clk,
  output logic o_reset_button
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_reset_button = 1'b0;
  // Press lasts n edges; changes only right after an edge
  task automatic press(input int n);
    @(posedge i_clk);
    o_reset_button <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_reset_button <= 1'b0;
  endtask
endmodule

// >>> verification/testbench.sv
// Self-checking bench of the safety output and restart control
module testbench;
  import sorc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0;
  logic i_reset = 1;
  logic [3:0] fld = 0;
  logic rd = 0;
  logic wr = 0;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0;
  logic btn, oe_n, io, msg, aux, irq, wq;
  logic [1:0] pair;
  logic [31:0] rdat;
  sorc_bank_t bank;
  logic pf_a, pf_b, wf_a, wf_b, aux_pin;
  logic [63:0] note;
  // Field pins of the scanner front end, one line each
  assign {wf_b, wf_a, pf_b, pf_a} = fld;
  // Two-way pin: pull-up while the block leaves it released
  assign aux_pin = oe_n ? 1'b1 : io;
  logic [63:0] q[$];
  logic [7:0] mm[6] = '{8'h1E, 8'h28, 8'h32, 8'h3C, 8'h46, 8'h96};
  int errors = 0;
  int checks_done = 0;
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  sorc_operator u_sorc_operator (.i_clk, .o_reset_button(btn));
  sorc_core #(.P_RST_MIN_CYC(20), .P_RST_MAX_CYC(100)) u_sorc_core (
    .i_clk, .i_reset, .i_pf_a_viol(pf_a), .i_pf_b_viol(pf_b),
    .i_wf_a_viol(wf_a), .i_wf_b_viol(wf_b), .i_reset_button(btn),
    .i_aux_inout_one(aux_pin), .o_aux_inout_one(io),
    .o_aux_inout_one_oe_n(oe_n), .o_safety_output_pair_a(pair),
    .o_nonsafe_message_output(msg), .o_aux_output_one(aux),
    .o_bank_cfg(bank), .o_irq(irq), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq));
  ////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, logic [31:0] d);
    int k;
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (!wq) break;
    end
    rd <= 0;
    wr <= 0;
    if (k == 20) begin
      errors++;
      $display("mismatch waitrequest exp 0 got 1");
      close_out();
    end
  endtask
  task automatic rdx(input logic [4:0] a, logic [31:0] m, e);
    q.push_back({m, e});
    bus(0, a, 0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic pwr();
    i_reset <= 1;
    wt(2);
    i_reset <= 0;
  endtask
  // Read data taken at the completing edge, oldest note first
  always @(posedge i_clk) begin
    if (rd && !wq && q.size() > 0) begin
      note = q.pop_front();
      chk("readdata", note[31:0], rdat & note[63:32]);
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    logic [5:0] r;
    logic [3:0] f;
    void'($urandom(2));
    wt(16);
    i_reset <= 0;
    rdx(OFS_CTRL, '1, CTRL_RST);
    rdx(OFS_ROUTE, '1, ROUTE_RST);
    rdx(5'h1C, '1, 0);
    wt(10);
    chk("pair", 0, pair);
    rdx(OFS_STATUS, 32'h00FF_01FF, 32'h001E_0180);
    bus(1, OFS_IRQ_ENABLE, 32'h0000_0008);
    u_sorc_operator.press(10);
    wt(8);
    chk("pair", 0, pair);
    chk("irq", 1, irq);
    rdx(OFS_IRQ_STATUS, 32'h0000_0008, 32'h0000_0008);
    bus(1, OFS_IRQ_CLEAR, 32'h0000_000F);
    wt(2);
    chk("irq", 0, irq);
    u_sorc_operator.press(150);
    wt(8);
    chk("pair", 0, pair);
    chk("irq", 1, irq);
    bus(1, OFS_IRQ_ENABLE, 0);
    u_sorc_operator.press(50);
    wt(8);
    chk("pair", 3, pair);
    chk("irq", 0, irq);
    fld <= 4'h1;
    wt(6);
    chk("pair", 0, pair);
    rdx(OFS_IRQ_STATUS, 32'h0000_000F, 32'h0000_000F);
    fld <= 4'h0;
    wt(10);
    chk("pair", 0, pair);
    u_sorc_operator.press(50);
    wt(8);
    bus(1, OFS_CTRL, 32'h0014_0006);
    fld <= 4'h2;
    wt(6);
    chk("pair", 3, pair);
    chk("msg", 1, msg);
    fld <= 0;
    pwr();
    bus(1, OFS_CTRL, 32'h0014_0084);
    wt(8);
    chk("pair", 3, pair);
    chk("oe_n", 0, oe_n);
    for (k = 0; k < 6; k++) begin
      bus(1, OFS_CTRL, {16'h0014, k[7:0], 1'b1, k[2:0], 4'h4});
      wt(2);
      chk("bank", {mm[k], k[7:0], 8'h14}, bank);
    end
    for (k = 0; k < 6; k++) begin
      r = 6'($urandom);
      f = 4'($urandom);
      bus(1, OFS_ROUTE, {26'h0, r});
      fld <= f;
      wt(6);
      chk("msg", f[r[1:0]], msg);
      chk("aux", f[r[3:2]], aux);
      chk("inout", f[r[5:4]], io);
    end
    fld <= 0;
    pwr();
    bus(1, OFS_CTRL, 32'h0014_0001);
    wt(10);
    chk("pair", 0, pair);
    u_sorc_operator.press(50);
    wt(8);
    fld <= 4'h1;
    wt(6);
    chk("pair", 0, pair);
    fld <= 0;
    wt(8);
    chk("pair", 3, pair);
    // Unsupported resolution code, then unsupported mode, keep pair off
    bus(1, OFS_CTRL, 32'h0014_0061);
    wt(4);
    chk("pair", 0, pair);
    chk("bank", 32'h0000_0014, bank);
    rdx(OFS_STATUS, 32'h0000_0100, 32'h0000_0000);
    bus(1, OFS_CTRL, 32'h0014_0001);
    wt(6);
    chk("pair", 3, pair);
    bus(1, OFS_CTRL, 32'h0014_0003);
    wt(4);
    chk("pair", 0, pair);
    close_out();
  end
endmodule
